// >>> logic/pfsm_pkg.sv
// Constants for the pin function select multiplexer: register offsets, masks,
// field layout, reset values and the pin function classes.
// Assumes an Avalon-MM master with 32-bit data and byte addresses.
//
// Contract
// - Port A pin 3: io with irq one, serial data out, analog 13, segment 19.
// - Port A pins 2 and 0 stay io except code 11, segments 23 and 24.
// - Port A pin 1: io with irq zero, chip select, analog 12, segment 20.
// - Port A pins 7, 6: io with irq, uart zero transmit or receive, segments 15, 16.
// - Port A pin 5: io with irq three, serial clock, analog 15, segment 17.
// - Port A pin 4: io with irq two, serial data in, analog 14, segment 18.
// - Port B pins 3, 2: io with capture inputs, timer outputs, segments 21, 14.
// - Port B pin 1 io, uart two, segment 25; pin 0 adds comparator zero.
// - Port B pins 7, 6: io or timer, crystal pins two and one, segments.
// - Port B pin 5 io with reset except 11; pin 4 comparator one output.
// - Port C pins 3, 2: io with timer inputs, timer outputs, analog, segments.
// - Port C pins 1, 0: io, reference voltage, analog, comparator or segment.
// - Port C pins 7, 6: io with inputs, timer outputs, analog 7 and 6, segments.
// - Port C pins 5, 4: io with inputs, timer outputs, analog 5 and 4, segments.
// - Port D pins 3, 2: io with inputs, timer outputs, uart one, analog.
// - Port D pins 1, 0: io, uart one or timer, analog 9 and 8, segments.
// - Top two bits of port D high select are unimplemented and read zero.
// - Port D pins 6, 5: io, timer or uart, comparator one, segments.
// - Port D pin 4: io with capture, timer output, uart zero, comparator input.
// - Port E pins 3..0: code 10 second serial port, code 11 segments 4..7.
// - Port E pins 7..5: bias and charge pump or segments; pin 4 io supply.
// - Port F pins 3, 2: io with clock inputs, serial clock and data, segments.
// - Port F pins 1, 0: io, timer outputs, serial data out and select, segments.
package pfsm_pkg;

   localparam int PFSM_NUM_REGS = 11;
   localparam int PFSM_NUM_PINS = 44;
   localparam int PFSM_PINS_PER_REG = 4;
   localparam int PFSM_FIELD_W = 2;
   localparam int PFSM_ADDR_W = 8;
   localparam int PFSM_DATA_W = 32;

   // Byte offsets, one aligned word per select register, index 0 first
   localparam logic [10:0][7:0] PFSM_REG_OFS = {
      8'h28, 8'h24, 8'h20, 8'h1c, 8'h18, 8'h14, 8'h10, 8'h0c, 8'h08, 8'h04, 8'h00};

   // Port D high select sits at index 7 and lacks its top field
   localparam int PFSM_PD_HIGH_IDX = 7;
   localparam logic [7:0] PFSM_WMASK_FULL = 8'hff;
   localparam logic [7:0] PFSM_WMASK_PD_HIGH = 8'h3f;
   localparam logic [7:0] PFSM_SEL_RESET = 8'h00;
   localparam logic [31:0] PFSM_UNMAPPED_RD = 32'h0000_0000;

   // Function class of a pin, two bits per select code in the map
   localparam logic [1:0] PFSM_CLS_IO = 2'h0;
   localparam logic [1:0] PFSM_CLS_DIG = 2'h1;
   localparam logic [1:0] PFSM_CLS_ANA = 2'h2;
   localparam logic [1:0] PFSM_CLS_LCD = 2'h3;

endpackage : pfsm_pkg

// >>> logic/pfsm_pin_mux.sv
// Pin function select multiplexer for ports A to E and pins 0..3 of port F.
// Holds eleven select registers behind an Avalon-MM slave and decodes every
// pin's two-bit field into one-hot function class enables for the pad ring.
// Assumes pins and peripherals downstream act on the class and field outputs.
//
// The Avalon-MM slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
module pfsm_pin_mux
   import pfsm_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Avalon-MM slave
   input wire logic [PFSM_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [PFSM_DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [PFSM_DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   // Per-pin select fields, pin p at bits 2p+1..2p
   output logic [2*PFSM_NUM_PINS-1:0] pin_field,
   // Per-pin one-hot function class enables
   output logic [PFSM_NUM_PINS-1:0] gpio_en,
   output logic [PFSM_NUM_PINS-1:0] periph_en,
   output logic [PFSM_NUM_PINS-1:0] analog_en,
   output logic [PFSM_NUM_PINS-1:0] lcd_en
);

   // Class map per pin: {code11, code10, code01, code00}, two bits each.
   // Pin p is port p/8, bit p%8; port D pin 7 does not exist.
   localparam logic [PFSM_NUM_PINS-1:0][7:0] CLS_MAP = {
      8'hd0, // PF3: io with clock in, io, serial clock, segment 10
      8'hd0, // PF2: io with clock in, io, serial data, segment 11
      8'hd4, // PF1: io, timer 6 out, data out, segment 12
      8'hd4, // PF0: io, timer 7 out, chip select, segment 13
      8'hf0, // PE7: io, io, bias level two, segment 43
      8'hf0, // PE6: io, io, pump cap one, segment 44
      8'hf0, // PE5: io, io, pump cap two, segment 45
      8'hc0, // PE4: io, io, io, io supply input
      8'hd4, // PE3: io with capture, timer out, second serial clock, segment 4
      8'hd4, // PE2: io with clock in, uart two tx, second serial data in, segment 5
      8'hd4, // PE1: io with capture, timer out, second serial data out, segment 6
      8'hd4, // PE0: io with clock in, uart two rx, second serial select, segment 7
      8'h00, // PD7: not implemented, always io
      8'hd4, // PD6: io with capture, timer out, comparator one out, segment 27
      8'he4, // PD5: io with clock in, uart zero tx, comparator one plus, segment 32
      8'h94, // PD4: io with capture, timer 3 out, uart zero, comparator minus
      8'he4, // PD3: io with inputs, timer 7 out, analog 11, segment 33
      8'h94, // PD2: io with capture, timer 2 out, uart one tx, analog 10
      8'he4, // PD1: io with clock in, uart one, analog 9, segment 34
      8'he4, // PD0: io with irq two, timer out, analog 8, segment 35
      8'he4, // PC7: io with inputs, timer 6 out, analog 7, segment 36
      8'hd8, // PC6: io with capture, analog 6, timer 0 out, segment 37
      8'he4, // PC5: io with inputs, timer 5 out, analog 5, segment 38
      8'hd8, // PC4: io with inputs, analog 4, timer 1 out, segment 39
      8'he4, // PC3: io with inputs, timer 4 out, analog 3, segment 40
      8'hd8, // PC2: io with inputs, analog 2, timer 0 out, segment 41
      8'h68, // PC1: io, reference out, analog 1, comparator zero out
      8'he8, // PC0: io, reference in, analog 0, segment 42
      8'he0, // PB7: io with clock in, io, crystal pin two, segment 28
      8'he4, // PB6: io with capture, timer 1 out, crystal pin one, segment 29
      8'hc0, // PB5: io with reset input, segment 30 only on 11
      8'hd0, // PB4: io, io, comparator one out, segment 22
      8'hd0, // PB3: io with capture, io, timer 2 out, segment 21
      8'hd0, // PB2: io with inputs, io, timer 3 out, segment 14
      8'hd0, // PB1: io with clock in, io, uart two tx, segment 25
      8'hd4, // PB0: io with clock in, uart two, comparator zero out, segment 26
      8'hd0, // PA7: io with irq one, io, uart zero tx, segment 15
      8'hd0, // PA6: io with irq zero, io, uart zero rx, segment 16
      8'he4, // PA5: io with irq three, serial clock, analog 15, segment 17
      8'he4, // PA4: io with irq two, serial data in, analog 14, segment 18
      8'he4, // PA3: io with irq one, serial data out, analog 13, segment 19
      8'hc0, // PA2: io unless 11, then segment 23
      8'he4, // PA1: io with irq zero, chip select, analog 12, segment 20
      8'hc0  // PA0: io unless 11, then segment 24
   };

   // Registers
   logic [7:0] sel_ff [PFSM_NUM_REGS];
   logic wait_ff;
   logic [PFSM_DATA_W-1:0] rdata_ff;
   logic [2*PFSM_NUM_PINS-1:0] field_ff;
   logic [PFSM_NUM_PINS-1:0] gpio_ff;
   logic [PFSM_NUM_PINS-1:0] periph_ff;
   logic [PFSM_NUM_PINS-1:0] analog_ff;
   logic [PFSM_NUM_PINS-1:0] lcd_ff;

   // Decode wires
   logic [PFSM_NUM_REGS-1:0] reg_hit;
   logic any_hit;
   logic req;
   logic wr_take;
   logic rd_take;
   logic [7:0] rd_byte;
   logic [PFSM_DATA_W-1:0] nxt_rdata;
   logic nxt_wait;
   logic [2*PFSM_NUM_PINS-1:0] nxt_field;
   logic [PFSM_NUM_PINS-1:0] nxt_gpio;
   logic [PFSM_NUM_PINS-1:0] nxt_periph;
   logic [PFSM_NUM_PINS-1:0] nxt_analog;
   logic [PFSM_NUM_PINS-1:0] nxt_lcd;

   // Bus handshake: one wait cycle, then the access completes.
   // A fixed latency keeps the slave free of any pending state to unwind.
   assign req = avs_read | avs_write;
   assign nxt_wait = ~(req & wait_ff);
   assign wr_take = avs_write & ~wait_ff;
   assign rd_take = avs_read & wait_ff;
   assign any_hit = |reg_hit;

   // Layout check: the pins must fill the select registers exactly, two bits each
   generate
      if (PFSM_NUM_PINS != PFSM_NUM_REGS * PFSM_PINS_PER_REG || PFSM_FIELD_W != 2) begin : g_bad_cfg
         $error("pin count does not match the select register layout");
      end
   endgenerate

   // Address decode against the word offsets
   generate
      for (genvar r = 0; r < PFSM_NUM_REGS; r++) begin : g_dec
         assign reg_hit[r] = (avs_address == PFSM_REG_OFS[r]);
      end
   endgenerate

   // Read mux, unmapped offsets read as zero
   always_comb begin
      rd_byte = 8'h00;
      for (int r = 0; r < PFSM_NUM_REGS; r++) begin
         if (reg_hit[r]) begin
            rd_byte = sel_ff[r];
         end
      end
   end
   assign nxt_rdata = any_hit ? {24'h00_0000, rd_byte} : PFSM_UNMAPPED_RD;

   // Select registers; writes land on the completing edge, low lane only
   generate
      for (genvar r = 0; r < PFSM_NUM_REGS; r++) begin : g_reg
         localparam logic [7:0] WMASK = (r == PFSM_PD_HIGH_IDX) ? PFSM_WMASK_PD_HIGH : PFSM_WMASK_FULL;
         logic [7:0] nxt_sel;
         assign nxt_sel = (wr_take & reg_hit[r] & avs_byteenable[0]) ? (avs_writedata[7:0] & WMASK) : sel_ff[r];
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               sel_ff[r] <= PFSM_SEL_RESET;
            end else begin
               sel_ff[r] <= nxt_sel;
            end
         end
      end
   endgenerate

   // Per-pin field select and class decode from the map
   generate
      for (genvar p = 0; p < PFSM_NUM_PINS; p++) begin : g_pin
         localparam int RI = p / PFSM_PINS_PER_REG;
         localparam int FB = PFSM_FIELD_W * (p % PFSM_PINS_PER_REG);
         logic [1:0] code;
         logic [1:0] cls;
         assign code = sel_ff[RI][FB+1:FB];
         assign cls = (code == 2'h0) ? CLS_MAP[p][1:0] :
                      (code == 2'h1) ? CLS_MAP[p][3:2] :
                      (code == 2'h2) ? CLS_MAP[p][5:4] : CLS_MAP[p][7:6];
         assign nxt_field[2*p+1:2*p] = code;
         assign nxt_gpio[p] = (cls == PFSM_CLS_IO);
         assign nxt_periph[p] = (cls == PFSM_CLS_DIG);
         assign nxt_analog[p] = (cls == PFSM_CLS_ANA);
         assign nxt_lcd[p] = (cls == PFSM_CLS_LCD);
      end
   endgenerate

   // Bus response flops
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wait_ff <= 1'b1;
         rdata_ff <= PFSM_UNMAPPED_RD;
      end else begin
         wait_ff <= nxt_wait;
         rdata_ff <= rd_take ? nxt_rdata : rdata_ff;
      end
   end

   // Pad-side flops; reset leaves every pin in general io
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         field_ff <= '0;
         gpio_ff <= '1;
         periph_ff <= '0;
         analog_ff <= '0;
         lcd_ff <= '0;
      end else begin
         field_ff <= nxt_field;
         gpio_ff <= nxt_gpio;
         periph_ff <= nxt_periph;
         analog_ff <= nxt_analog;
         lcd_ff <= nxt_lcd;
      end
   end

   // Outputs straight from flops
   assign avs_readdata = rdata_ff;
   assign avs_waitrequest = wait_ff;
   assign pin_field = field_ff;
   assign gpio_en = gpio_ff;
   assign periph_en = periph_ff;
   assign analog_en = analog_ff;
   assign lcd_en = lcd_ff;

   // Checks on the routing and the bus
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_req_waiting;
      req && wait_ff;
   endsequence

   sequence s_done;
      !wait_ff ##1 wait_ff;
   endsequence

   bus_answer_a: assert property (s_req_waiting |=> s_done)
      else $error("access not completed after one wait cycle");

   pd_top_zero_a: assert property (sel_ff[PFSM_PD_HIGH_IDX][7:6] == 2'h0)
      else $error("unimplemented port D field holds a one");

   pd7_always_io_a: assert property (gpio_ff[31])
      else $error("missing port D pin 7 left io mode");

   pa3_analog_a: assert property (sel_ff[0][7:6] == 2'h2 |=> analog_ff[3] && !gpio_ff[3])
      else $error("port A pin 3 code 10 not analog");

   pa0_io_keep_a: assert property (sel_ff[0][1:0] != 2'h3 |=> gpio_ff[0] && !lcd_ff[0])
      else $error("port A pin 0 left io below code 11");

   pa1_periph_a: assert property (sel_ff[0][3:2] == 2'h1 |=> periph_ff[1])
      else $error("port A pin 1 code 01 not chip select");

   pa7_low_io_a: assert property (sel_ff[1][7] == 1'b0 |=> gpio_ff[7])
      else $error("port A pin 7 low codes not io");

   pb5_reset_io_a: assert property (sel_ff[3][3:2] != 2'h3 |=> gpio_ff[13])
      else $error("port B pin 5 lost reset io function");

   pc1_comp_a: assert property (sel_ff[4][3:2] == 2'h3 |=> periph_ff[17] && !lcd_ff[17])
      else $error("port C pin 1 code 11 not comparator output");

   pd4_cmp_in_a: assert property (sel_ff[7][1:0] == 2'h3 |=> analog_ff[28])
      else $error("port D pin 4 code 11 not comparator input");

   pe_serial_a: assert property (sel_ff[8][7:6] == 2'h2 |=> periph_ff[35])
      else $error("port E pin 3 code 10 not second serial clock");

   pe4_supply_a: assert property (sel_ff[9][1:0] == 2'h3 |=> lcd_ff[36] && !gpio_ff[36])
      else $error("port E pin 4 code 11 not supply input");

   pf0_sel_a: assert property (sel_ff[10][1:0] == 2'h2 |=> periph_ff[40])
      else $error("port F pin 0 code 10 not chip select");

   onehot_cls_a: assert property ($onehot({gpio_ff[9], periph_ff[9], analog_ff[9], lcd_ff[9]}))
      else $error("port B pin 1 class not one-hot");

   field_follow_a: assert property (pin_field[43:42] == $past(sel_ff[5][3:2]))
      else $error("port C pin 5 field output stale");

   pa3_lcd_a: assert property (sel_ff[0][7:6] == 2'h3 |=> lcd_ff[3])
      else $error("port A pin 3 code 11 not segment");

   pa3_serial_a: assert property (sel_ff[0][7:6] == 2'h1 |=> periph_ff[3])
      else $error("port A pin 3 code 01 not serial data out");

   pa2_seg_a: assert property (sel_ff[0][5:4] == 2'h3 |=> lcd_ff[2])
      else $error("port A pin 2 code 11 not segment");

   pa2_io_keep_a: assert property (sel_ff[0][5:4] != 2'h3 |=> gpio_ff[2])
      else $error("port A pin 2 left io below code 11");

   pa1_analog_a: assert property (sel_ff[0][3:2] == 2'h2 |=> analog_ff[1])
      else $error("port A pin 1 code 10 not analog");

   pa7_seg_a: assert property (sel_ff[1][7:6] == 2'h3 |=> lcd_ff[7])
      else $error("port A pin 7 code 11 not segment");

   pa6_uart_a: assert property (sel_ff[1][5:4] == 2'h2 |=> periph_ff[6])
      else $error("port A pin 6 code 10 not uart");

   pa5_clock_a: assert property (sel_ff[1][3:2] == 2'h1 |=> periph_ff[5])
      else $error("port A pin 5 code 01 not serial clock");

   pa4_data_in_a: assert property (sel_ff[1][1:0] == 2'h1 |=> periph_ff[4])
      else $error("port A pin 4 code 01 not serial data in");

   pb3_timer_a: assert property (sel_ff[2][7:6] == 2'h2 |=> periph_ff[11])
      else $error("port B pin 3 code 10 not timer output");

   pb2_io_a: assert property (sel_ff[2][5] == 1'b0 |=> gpio_ff[10])
      else $error("port B pin 2 low codes not io");

   pb1_uart_a: assert property (sel_ff[2][3:2] == 2'h2 |=> periph_ff[9])
      else $error("port B pin 1 code 10 not uart transmit");

   pb0_uart_a: assert property (sel_ff[2][1:0] == 2'h1 |=> periph_ff[8])
      else $error("port B pin 0 code 01 not uart");

   pb7_crystal_a: assert property (sel_ff[3][7:6] == 2'h2 |=> analog_ff[15])
      else $error("port B pin 7 code 10 not crystal pin");

   pb6_timer_a: assert property (sel_ff[3][5:4] == 2'h1 |=> periph_ff[14])
      else $error("port B pin 6 code 01 not timer output");

   pb5_seg_a: assert property (sel_ff[3][3:2] == 2'h3 |=> lcd_ff[13])
      else $error("port B pin 5 code 11 not segment");

   pb4_comp_a: assert property (sel_ff[3][1:0] == 2'h2 |=> periph_ff[12])
      else $error("port B pin 4 code 10 not comparator output");

   pc3_timer_a: assert property (sel_ff[4][7:6] == 2'h1 |=> periph_ff[19])
      else $error("port C pin 3 code 01 not timer output");

   pc2_analog_a: assert property (sel_ff[4][5:4] == 2'h1 |=> analog_ff[18])
      else $error("port C pin 2 code 01 not analog");

   pc0_ref_in_a: assert property (sel_ff[4][1:0] == 2'h1 |=> analog_ff[16])
      else $error("port C pin 0 code 01 not reference input");

   pc7_timer_a: assert property (sel_ff[5][7:6] == 2'h1 |=> periph_ff[23])
      else $error("port C pin 7 code 01 not timer output");

   pc6_timer_a: assert property (sel_ff[5][5:4] == 2'h2 |=> periph_ff[22])
      else $error("port C pin 6 code 10 not timer output");

   pc5_analog_a: assert property (sel_ff[5][3:2] == 2'h2 |=> analog_ff[21])
      else $error("port C pin 5 code 10 not analog");

   pc4_timer_a: assert property (sel_ff[5][1:0] == 2'h2 |=> periph_ff[20])
      else $error("port C pin 4 code 10 not timer output");

   pd3_seg_a: assert property (sel_ff[6][7:6] == 2'h3 |=> lcd_ff[27])
      else $error("port D pin 3 code 11 not segment");

   pd2_analog_a: assert property (sel_ff[6][5:4] == 2'h3 |=> analog_ff[26])
      else $error("port D pin 2 code 11 not analog");

   pd1_uart_a: assert property (sel_ff[6][3:2] == 2'h1 |=> periph_ff[25])
      else $error("port D pin 1 code 01 not uart");

   pd6_comp_a: assert property (sel_ff[7][5:4] == 2'h2 |=> periph_ff[30])
      else $error("port D pin 6 code 10 not comparator output");

   pd5_cmp_in_a: assert property (sel_ff[7][3:2] == 2'h2 |=> analog_ff[29])
      else $error("port D pin 5 code 10 not comparator input");

   pd4_uart_a: assert property (sel_ff[7][1:0] == 2'h2 |=> periph_ff[28])
      else $error("port D pin 4 code 10 not uart");

   pe0_seg_a: assert property (sel_ff[8][1:0] == 2'h3 |=> lcd_ff[32])
      else $error("port E pin 0 code 11 not segment");

   pe7_bias_a: assert property (sel_ff[9][7:6] == 2'h2 |=> lcd_ff[39])
      else $error("port E pin 7 code 10 not bias pin");

   pf3_clock_a: assert property (sel_ff[10][7:6] == 2'h2 |=> periph_ff[43])
      else $error("port F pin 3 code 10 not serial clock");

   pf1_data_out_a: assert property (sel_ff[10][3:2] == 2'h2 |=> periph_ff[41])
      else $error("port F pin 1 code 10 not serial data out");

   // A completed write with lane 0 set lands in the register on the next edge
   sequence s_wr_pa_low;
      wr_take && reg_hit[0] && avs_byteenable[0];
   endsequence

   write_lands_a: assert property (s_wr_pa_low |=> sel_ff[0] == $past(avs_writedata[7:0]))
      else $error("port A low select missed a write");

   read_data_a: assert property (rd_take && reg_hit[2] |=> avs_readdata == {24'h00_0000, $past(sel_ff[2])})
      else $error("port B low select read wrong value");

   reset_io_a: assert property ($fell(rst) |-> &gpio_ff && lcd_ff == '0 && sel_ff[3] == PFSM_SEL_RESET)
      else $error("pins not in io after reset");

   // Every pin carries exactly one function class
   generate
      for (genvar p = 0; p < PFSM_NUM_PINS; p++) begin : g_chk
         pin_onehot_a: assert property ($onehot({gpio_ff[p], periph_ff[p], analog_ff[p], lcd_ff[p]}))
            else $error("pin class enables not one-hot");
      end
   endgenerate

endmodule : pfsm_pin_mux

// >>> dv/pfsm_pad_model.sv
// Stand-in for the pad ring and peripherals behind the pin function mux.
// Assumes one class enable per pin; turns them back into a class code per pad.
`timescale 1ns/10ps
module pfsm_pad_model
   import pfsm_pkg::*;
(
   // Class enables from the mux
   input wire logic [PFSM_NUM_PINS-1:0] gpio_en,
   input wire logic [PFSM_NUM_PINS-1:0] periph_en,
   input wire logic [PFSM_NUM_PINS-1:0] analog_en,
   input wire logic [PFSM_NUM_PINS-1:0] lcd_en,
   // Class code each pad acts on, and a flag for pads with no claim or more than one
   output logic [2*PFSM_NUM_PINS-1:0] pad_cls,
   output logic cls_fault
);
   // Peripherals only take a pad once its class is selected; software orders enables around that
   always_comb begin
      cls_fault = 1'b0;
      for (int p = 0; p < PFSM_NUM_PINS; p++) begin
         pad_cls[2*p +: 2] = {analog_en[p] | lcd_en[p], periph_en[p] | lcd_en[p]};
         // Two claims on one pad would short two drivers together
         if ((4'(gpio_en[p]) + 4'(periph_en[p]) + 4'(analog_en[p]) + 4'(lcd_en[p])) != 4'h1) begin
            cls_fault = 1'b1;
         end
      end
   end
endmodule : pfsm_pad_model

// >>> dv/tb.sv
// Self-checking bench for the pin function select mux.
// Assumes a one-cycle waitrequest low per access and pads that follow a clock later.
`timescale 1ns/10ps
module tb
   import pfsm_pkg::*;
();
   // Expected class per pin, two bits per code with code 00 lowest: io 0, digital 1, analog 2, lcd 3
   localparam logic [43:0][7:0] cls_tbl = {8'hd0, 8'hd0, 8'hd4, 8'hd4,
      8'hf0, 8'hf0, 8'hf0, 8'hc0, 8'hd4, 8'hd4, 8'hd4, 8'hd4, 8'h00, 8'hd4, 8'he4, 8'h94, 8'he4, 8'h94, 8'he4, 8'he4,
      8'he4, 8'hd8, 8'he4, 8'hd8, 8'he4, 8'hd8, 8'h68, 8'he8, 8'he0, 8'he4, 8'hc0, 8'hd0, 8'hd0, 8'hd0, 8'hd0, 8'hd4,
      8'hd0, 8'hd0, 8'he4, 8'he4, 8'he4, 8'hc0, 8'he4, 8'hc0};
   logic clk, rst, avs_read, avs_write, avs_waitrequest, cls_fault;
   logic [7:0] avs_address;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, exp_rd;
   logic [87:0] pin_field, pad_cls;
   logic [43:0] gpio_en, periph_en, analog_en, lcd_en;
   logic [10:0][7:0] shadow;
   logic [31:0] rd_q[$];
   int errors, tests_run;

   pfsm_pin_mux uut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_field(pin_field),
      .gpio_en(gpio_en), .periph_en(periph_en), .analog_en(analog_en), .lcd_en(lcd_en));
   pfsm_pad_model pad (.gpio_en(gpio_en), .periph_en(periph_en), .analog_en(analog_en),
      .lcd_en(lcd_en), .pad_cls(pad_cls), .cls_fault(cls_fault));

   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task check(input string what, input logic [87:0] seen, input logic [87:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task finish_test;
      if (errors == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finish_test

   // One Avalon access, held until waitrequest is sampled low; bounded so a stuck slave ends the run
   task bus(input logic wr, input logic [7:0] addr, input logic [31:0] data, input logic [3:0] be);
      int n;
      n = 0;
      avs_address <= addr;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= data;
      avs_byteenable <= be;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) begin
         n++;
         if (n > 20) begin
            errors++;
            finish_test;
         end
         @(posedge clk);
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask : bus

   // Index 11 lands on the unmapped word after the last register
   task wr(input int idx, input logic [7:0] d, input logic [3:0] be);
      if (idx < PFSM_NUM_REGS && be[0]) begin
         shadow[idx] = d & ((idx == PFSM_PD_HIGH_IDX) ? PFSM_WMASK_PD_HIGH : PFSM_WMASK_FULL);
      end
      bus(1'b1, 8'(4*idx), {24'($urandom), d}, be);
   endtask : wr

   task rd(input int idx);
      rd_q.push_back((idx < PFSM_NUM_REGS) ? {24'h0, shadow[idx]} : PFSM_UNMAPPED_RD);
      bus(1'b0, 8'(4*idx), 32'h0, 4'hf);
   endtask : rd

   // Pads settle one clock after the register; compare every pin's class and field
   task pads;
      logic [87:0] e;
      int c;
      repeat (2) @(posedge clk);
      #1;
      for (int p = 0; p < PFSM_NUM_PINS; p++) begin
         c = int'(shadow[p/4][2*(p%4) +: 2]);
         e[2*p +: 2] = cls_tbl[p][2*c +: 2];
      end
      check("pad_class", pad_cls, e);
      check("pin_field", pin_field, shadow);
      check("class_onehot", 88'(cls_fault), 88'h0);
      @(posedge clk);
   endtask : pads

   // Read results are matched in issue order against the driver's notes
   always @(posedge clk) begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
         exp_rd = (rd_q.size() > 0) ? rd_q.pop_front() : 'x;
         check("readdata", 88'(avs_readdata), 88'(exp_rd));
      end
   end

   // Reset, every code in every field, random traffic, then a reset in mid-run
   initial begin
      rst = 1'b1;
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
      shadow = '0;
      errors = 0;
      tests_run = 0;
      void'($urandom(32'h2a1d8553));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      pads;
      for (int i = 0; i <= PFSM_NUM_REGS; i++) rd(i);
      for (int c = 0; c < 4; c++) begin
         for (int i = 0; i < PFSM_NUM_REGS; i++) wr(i, {4{2'(c)}}, 4'hf);
         pads;
         for (int i = 0; i <= PFSM_NUM_REGS; i++) rd(i);
      end
      // Random lane enables leave some writes dropped; unmapped index mixed in
      for (int k = 0; k < 60; k++) begin
         wr(int'($urandom_range(11, 0)), 8'($urandom), 4'($urandom));
         rd(int'($urandom_range(11, 0)));
         if (k % 6 == 5) pads;
      end
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      shadow = '0;
      pads;
      rd(PFSM_PD_HIGH_IDX);
      repeat (4) @(posedge clk);
      finish_test;
   end
endmodule : tb
